// ==== shared/boot_guard_defines.svh ====
// What this block does
// - Program-store fetched from the application section is ignored, nothing starts.
// - Program-store starts erase or write only when executing from boot loader section.
// - Boot code may target any page, boot pages too, subject to locks.
// - Boot size fuses set the section boundary; each section has its own locks.
// - Concurrent-read region programming keeps CPU running and serving halting-region fetches.
// - Halting-region programming halts the CPU until the operation finishes.
// - Boot loader section always lies inside the halting region.
// - Busy flag reads one while concurrent-read region is blocked.
// - Locks programmed by software or programming modes; only chip erase clears them.
// - General write-lock mode 2 does not affect program-store programming.
// - General read/write lock mode 1 does not govern load or store accesses.
// - Application locks: mode 1 unrestricted, mode 2 blocks stores to application.
// - Application modes 3 and 4 block boot-code loads; mode 3 blocks stores.
// - Application modes 3/4, vectors in boot: suppress interrupts running application.
// - Boot locks: mode 1 unrestricted, mode 2 blocks stores to boot section.
// - Boot modes 3 and 4 block application-code loads; mode 3 blocks stores.
// - Boot modes 3/4, vectors in application: suppress interrupts running boot code.
// - Lock bit reads one when unprogrammed and zero when programmed.
// - Busy flag sets when erase or write to concurrent-read region starts.
// - Busy flag clears on re-enable after completion, or when page load starts.
`ifndef BOOT_GUARD_DEFINES_SVH
`define BOOT_GUARD_DEFINES_SVH

`define ADDR_W 13
`define FLASH_TOP 14'h2000
`define HALT_REGION_START 13'h1C00
`define BOOT_SIZE_0 14'h0400
`define BOOT_SIZE_1 14'h0200
`define BOOT_SIZE_2 14'h0100
`define BOOT_SIZE_3 14'h0080

`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_LOCK 4'h8
`define REG_CFG 4'hC

`define CTRL_REENABLE 0
`define CTRL_VEC_BOOT 1
`define LOCK_APP_LOWER 0
`define LOCK_APP_UPPER 1
`define LOCK_BOOT_LOWER 2
`define LOCK_BOOT_UPPER 3
`define LOCK_ERASED 4'hF
`define CFG_START_LSB 16
`define STAT_BUSY 0
`define STAT_ACTIVE 1
`define STAT_HALT 2
`define STAT_DENIED 3

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== shared/boot_guard_pkg.sv ====
package boot_guard_pkg;
  typedef logic [12:0] word_addr_t;
  typedef enum logic [2:0] {
    OP_IDLE = 3'h1,
    OP_CONCURRENT = 3'h2,
    OP_HALTING = 3'h4
  } op_state_e;
endpackage

// ==== hdl/boot_flash_self_program_guard.sv ====
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "boot_guard_defines.svh"
module boot_flash_self_program_guard (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic [1:0] boot_size_fuses,
  input wire logic [3:0] lock_stored,
  input wire logic prog_lock_set,
  input wire logic [3:0] prog_lock_data,
  input wire logic chip_erase,
  input wire logic store_req,
  input wire logic store_erase,
  input wire boot_guard_pkg::word_addr_t store_pc,
  input wire boot_guard_pkg::word_addr_t store_page,
  input wire logic load_req,
  input wire boot_guard_pkg::word_addr_t load_pc,
  input wire boot_guard_pkg::word_addr_t load_addr,
  input wire logic page_load,
  input wire boot_guard_pkg::word_addr_t fetch_pc,
  input wire logic flash_done,
  output logic store_grant,
  output logic store_deny,
  output logic load_grant,
  output logic load_deny,
  output logic flash_erase_start,
  output logic flash_write_start,
  output boot_guard_pkg::word_addr_t flash_page,
  output logic cpu_halt,
  output logic concurrent_read_busy_flag,
  output logic irq_suppress
);
  import boot_guard_pkg::*;

  // ****************************************
  // Section map
  // ****************************************
  function automatic logic [13:0] boot_size(input logic [1:0] fuses);
    logic [13:0] size;
    size = `BOOT_SIZE_3;
    if (fuses == 2'h0) begin
      size = `BOOT_SIZE_0;
    end else if (fuses == 2'h1) begin
      size = `BOOT_SIZE_1;
    end else if (fuses == 2'h2) begin
      size = `BOOT_SIZE_2;
    end
    return size;
  endfunction

  function automatic logic in_boot(input word_addr_t a, input word_addr_t start);
    return a >= start;
  endfunction

  // Offsets that answer OKAY; anything else gets SLVERR
  function automatic logic reg_mapped(input logic [3:0] a);
    return (a == `REG_CTRL) | (a == `REG_STATUS) | (a == `REG_LOCK) | (a == `REG_CFG);
  endfunction

  logic [1:0] fuse_meta;
  logic [1:0] fuse_sync;
  logic [3:0] lock_bits;
  logic lock_loaded;
  logic vec_boot;
  logic last_denied;
  op_state_e state;
  op_state_e next_state;

  // Boot section always sits at the top, which is inside the halting region
  // boundary from fuses
  wire [13:0] boot_start_w = `FLASH_TOP - boot_size(fuse_sync);
  wire word_addr_t boot_start = boot_start_w[12:0];

  // Lock bits: 1 unprogrammed, 0 programmed
  // lock polarity
  wire app_store_lock = ~lock_bits[`LOCK_APP_LOWER];
  wire app_load_lock = ~lock_bits[`LOCK_APP_UPPER];
  wire boot_store_lock = ~lock_bits[`LOCK_BOOT_LOWER];
  wire boot_load_lock = ~lock_bits[`LOCK_BOOT_UPPER];

  // ****************************************
  // Program-store decision
  // ****************************************
  // boot-only stores
  wire store_from_boot = in_boot(store_pc, boot_start);
  wire target_boot = in_boot(store_page, boot_start);
  // store locks; general locks not consulted
  wire target_locked = target_boot ? boot_store_lock : app_store_lock;
  wire op_idle = state == OP_IDLE;
  wire store_ok = store_req & store_from_boot & ~target_locked & op_idle;
  wire target_halting = store_page >= `HALT_REGION_START;

  // ****************************************
  // Program-load decision
  // ****************************************
  // cross-section load blocking
  wire load_from_boot = in_boot(load_pc, boot_start);
  wire load_to_boot = in_boot(load_addr, boot_start);
  wire load_blocked = (load_from_boot & ~load_to_boot & app_load_lock) |
                      (~load_from_boot & load_to_boot & boot_load_lock);

  wire fetch_boot = in_boot(fetch_pc, boot_start);
  wire next_irq_suppress = (app_load_lock & vec_boot & ~fetch_boot) |
                           (boot_load_lock & ~vec_boot & fetch_boot);

  // ****************************************
  // Operation sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    case (state)
      OP_IDLE: begin
        if (store_ok) begin
          next_state = target_halting ? OP_HALTING : OP_CONCURRENT;
        end
      end
      OP_CONCURRENT, OP_HALTING: begin
        if (flash_done) begin
          next_state = OP_IDLE;
        end
      end
      default: begin
        next_state = OP_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= OP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // Register bus
  // ****************************************
  logic aw_held;
  logic w_held;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  wire aw_take = s_awvalid & s_awready;
  wire w_take = s_wvalid & s_wready;
  wire have_aw = aw_held | aw_take;
  wire have_w = w_held | w_take;
  wire wr_do = have_aw & have_w & ~s_bvalid;
  wire [3:0] wr_addr = aw_held ? awaddr_q : s_awaddr;
  wire [31:0] wr_data = w_held ? wdata_q : s_wdata;
  wire [3:0] wr_strb = w_held ? wstrb_q : s_wstrb;
  wire next_aw_held = have_aw & ~wr_do;
  wire next_w_held = have_w & ~wr_do;
  wire next_bvalid = wr_do | (s_bvalid & ~s_bready);
  wire wr_byte0 = wr_do & wr_strb[0];
  wire wr_ctrl = wr_byte0 & (wr_addr == `REG_CTRL);
  wire wr_lock = wr_byte0 & (wr_addr == `REG_LOCK);
  wire wr_mapped = reg_mapped(wr_addr);
  wire [1:0] next_bresp = wr_mapped ? `RESP_OKAY : `RESP_SLVERR;

  wire ar_take = s_arvalid & s_arready;
  wire next_rvalid = ar_take | (s_rvalid & ~s_rready);
  wire rd_mapped = reg_mapped(s_araddr);
  wire [1:0] next_rresp = rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
  wire [31:0] rd_ctrl = 32'(vec_boot) << `CTRL_VEC_BOOT;
  wire [31:0] rd_status = (32'(concurrent_read_busy_flag) << `STAT_BUSY) |
                          (32'(!op_idle) << `STAT_ACTIVE) |
                          (32'(cpu_halt) << `STAT_HALT) |
                          (32'(last_denied) << `STAT_DENIED);
  wire [31:0] rd_lock = {28'h0, lock_bits};
  wire [31:0] rd_cfg = (32'(boot_start) << `CFG_START_LSB) | 32'(fuse_sync);
  wire [31:0] rd_value = (s_araddr == `REG_CTRL) ? rd_ctrl :
                         (s_araddr == `REG_STATUS) ? rd_status :
                         (s_araddr == `REG_LOCK) ? rd_lock :
                         (s_araddr == `REG_CFG) ? rd_cfg : 32'h0;

  // Channel holding flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q <= 4'h0;
    end else if (aw_take) begin
      awaddr_q <= s_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else if (w_take) begin
      wdata_q <= s_wdata;
      wstrb_q <= s_wstrb;
    end
  end

  // Readies drop while a response waits, so at most one write and one read are open
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_arready <= 1'b0;
    end else begin
      s_awready <= ~next_aw_held & ~next_bvalid;
      s_wready <= ~next_w_held & ~next_bvalid;
      s_arready <= ~next_rvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp <= `RESP_OKAY;
    end else begin
      s_bvalid <= next_bvalid;
      if (wr_do) begin
        s_bresp <= next_bresp;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0;
      s_rresp <= `RESP_OKAY;
    end else begin
      s_rvalid <= next_rvalid;
      if (ar_take) begin
        s_rdata <= rd_value;
        s_rresp <= next_rresp;
      end
    end
  end

  // ****************************************
  // Fuses, locks and control
  // ****************************************
  // Fuses are static pins; synchronised anyway so a slow settle cannot glitch decode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fuse_meta <= 2'h0;
      fuse_sync <= 2'h0;
    end else begin
      fuse_meta <= boot_size_fuses;
      fuse_sync <= fuse_meta;
    end
  end

  // Stored locks are copied once after reset; AND only ever programs bits
  // program only, chip erase clears
  wire [3:0] lock_prog = (wr_lock ? wr_data[3:0] : `LOCK_ERASED) &
                         (prog_lock_set ? prog_lock_data : `LOCK_ERASED);
  wire [3:0] next_lock = chip_erase ? `LOCK_ERASED :
                         (lock_loaded ? lock_bits : lock_stored) & lock_prog;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_bits <= `LOCK_ERASED;
      lock_loaded <= 1'b0;
    end else begin
      lock_bits <= next_lock;
      lock_loaded <= 1'b1;
    end
  end

  // Vector placement only steers interrupt suppression
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vec_boot <= 1'b0;
    end else if (wr_ctrl) begin
      vec_boot <= wr_data[`CTRL_VEC_BOOT];
    end
  end

  // Re-enable is refused while an operation runs; a start in the same cycle wins
  // busy flag set and clear
  wire busy_set = store_ok & ~target_halting;
  wire busy_clr = (wr_ctrl & wr_data[`CTRL_REENABLE] & op_idle) | page_load;
  wire next_busy = busy_set | (concurrent_read_busy_flag & ~busy_clr);

  // ****************************************
  // Outputs to CPU and flash
  // ****************************************
  wire next_store_deny = store_req & ~store_ok;
  wire next_load_grant = load_req & ~load_blocked;
  wire next_load_deny = load_req & load_blocked;
  wire next_erase_start = store_ok & store_erase;
  wire next_write_start = store_ok & ~store_erase;
  wire next_halt = next_state == OP_HALTING;
  wire any_req = store_req | load_req;
  wire next_last_denied = next_store_deny | next_load_deny;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      concurrent_read_busy_flag <= 1'b0;
    end else begin
      concurrent_read_busy_flag <= next_busy;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      store_grant <= 1'b0;
      store_deny <= 1'b0;
      load_grant <= 1'b0;
      load_deny <= 1'b0;
    end else begin
      store_grant <= store_ok;
      store_deny <= next_store_deny;
      load_grant <= next_load_grant;
      load_deny <= next_load_deny;
    end
  end

  // Start pulses and page move together so the macro never sees a stale page
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_erase_start <= 1'b0;
      flash_write_start <= 1'b0;
      flash_page <= '0;
    end else begin
      flash_erase_start <= next_erase_start;
      flash_write_start <= next_write_start;
      if (store_ok) begin
        flash_page <= store_page;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_halt <= 1'b0;
      irq_suppress <= 1'b0;
    end else begin
      cpu_halt <= next_halt;
      irq_suppress <= next_irq_suppress;
    end
  end

  // Holds the verdict of the latest request until the next one arrives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_denied <= 1'b0;
    end else if (any_req) begin
      last_denied <= next_last_denied;
    end
  end

endmodule

// ==== verif/flash_macro_model.sv ====
`timescale 1ns/100ps
module flash_macro_model #(
  parameter int DELAY = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  output logic done
);
  int cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn || start) begin
      cnt <= start ? DELAY : 0;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
    done <= aresetn && !start && cnt == 1;
  end
endmodule

// ==== verif/guard_asserts.sv ====
`timescale 1ns/100ps
module guard_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic store_req,
  input wire logic store_erase,
  input wire boot_guard_pkg::word_addr_t store_pc,
  input wire boot_guard_pkg::word_addr_t store_page,
  input wire logic load_req,
  input wire logic page_load,
  input wire logic flash_done,
  input wire logic store_grant,
  input wire logic store_deny,
  input wire logic load_grant,
  input wire logic load_deny,
  input wire logic flash_erase_start,
  input wire logic flash_write_start,
  input wire boot_guard_pkg::word_addr_t flash_page,
  input wire logic cpu_halt,
  input wire logic concurrent_read_busy_flag
);
  import boot_guard_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_app_ignored: assert property (store_req && store_pc < 13'h1C00 |=>
    store_deny && !flash_write_start && !flash_erase_start) else $error("app store ran");
  a_one_answer: assert property (store_req |=> store_grant != store_deny)
    else $error("store answer");
  a_erase_kind: assert property (store_req && store_erase ##1 store_grant |->
    flash_erase_start && !flash_write_start) else $error("erase kind");
  a_page_latch: assert property (store_req ##1 store_grant |->
    flash_page == $past(store_page)) else $error("page latch");
  a_halt_start: assert property (store_grant && flash_page >= 13'h1C00 |-> cpu_halt)
    else $error("no halt");
  a_rww_run: assert property (store_grant && flash_page < 13'h1C00 |->
    concurrent_read_busy_flag && !cpu_halt) else $error("rww start");
  a_halt_hold: assert property (cpu_halt && !flash_done |=> cpu_halt)
    else $error("halt dropped");
  a_halt_end: assert property (cpu_halt && flash_done |=> !cpu_halt)
    else $error("halt stuck");
  a_load_answer: assert property (load_req |=> load_grant != load_deny)
    else $error("load answer");
  a_pl_clear: assert property (page_load && !store_req |=> !concurrent_read_busy_flag)
    else $error("busy kept");
endmodule
bind boot_flash_self_program_guard guard_asserts u_chk (.aclk, .aresetn, .store_req,
  .store_erase, .store_pc, .store_page, .load_req, .page_load, .flash_done, .store_grant,
  .store_deny, .load_grant, .load_deny, .flash_erase_start, .flash_write_start, .flash_page,
  .cpu_halt, .concurrent_read_busy_flag);

// ==== verif/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  import boot_guard_pkg::*;
  logic aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, prog_lock_set, chip_erase, store_req;
  logic store_erase, load_req, page_load, flash_done, store_grant, store_deny, load_grant;
  logic load_deny, flash_erase_start, flash_write_start, cpu_halt, irq_suppress;
  logic concurrent_read_busy_flag;
  logic [3:0] s_awaddr, s_wstrb, s_araddr, lock_stored, prog_lock_data;
  logic [31:0] s_wdata, s_rdata, d;
  logic [1:0] s_bresp, s_rresp, boot_size_fuses, r;
  word_addr_t store_pc, store_page, load_pc, load_addr, fetch_pc, flash_page;
  int err_total, checks_done;
  boot_flash_self_program_guard dut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready,
    .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
    .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .boot_size_fuses,
    .lock_stored, .prog_lock_set, .prog_lock_data, .chip_erase, .store_req, .store_erase,
    .store_pc, .store_page, .load_req, .load_pc, .load_addr, .page_load, .fetch_pc,
    .flash_done, .store_grant, .store_deny, .load_grant, .load_deny, .flash_erase_start,
    .flash_write_start, .flash_page, .cpu_halt, .concurrent_read_busy_flag, .irq_suppress);
  flash_macro_model u_flash (.aclk, .aresetn, .start(flash_erase_start | flash_write_start),
    .done(flash_done));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task chk(input bit ok, input string m);
    checks_done++;
    if (!ok) begin
      err_total++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task axw(input logic [3:0] a, input logic [31:0] wd, output logic [1:0] rr);
    bit a_ok, w_ok;
    a_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= wd;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    while (!(a_ok && w_ok)) begin
      @(posedge aclk);
      if (s_awready === 1'b1) begin
        a_ok = 1;
        s_awvalid <= 1'b0;
      end
      if (s_wready === 1'b1) begin
        w_ok = 1;
        s_wvalid <= 1'b0;
      end
    end
    s_bready <= 1'b1;
    do @(posedge aclk); while (s_bvalid !== 1'b1);
    rr = s_bresp;
    s_bready <= 1'b0;
  endtask
  task axr(input logic [3:0] a, output logic [31:0] rd, output logic [1:0] rr);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do @(posedge aclk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    s_rready <= 1'b1;
    do @(posedge aclk); while (s_rvalid !== 1'b1);
    rd = s_rdata;
    rr = s_rresp;
    s_rready <= 1'b0;
  endtask
  task sreq(input word_addr_t pc, input word_addr_t pg, input logic er);
    @(posedge aclk);
    store_req <= 1'b1;
    store_pc <= pc;
    store_page <= pg;
    store_erase <= er;
    @(posedge aclk);
    store_req <= 1'b0;
    #1;
  endtask
  task lreq(input word_addr_t pc, input word_addr_t ad);
    @(posedge aclk);
    load_req <= 1'b1;
    load_pc <= pc;
    load_addr <= ad;
    @(posedge aclk);
    load_req <= 1'b0;
    #1;
  endtask
  task wdone;
    int n;
    n = 0;
    while (flash_done !== 1'b1 && n < 100) begin
      @(posedge aclk);
      #1;
      n++;
    end
    chk(n < 100, "no flash done");
    @(posedge aclk);
    #1;
  endtask
  task t_regs;
    axr(4'hC, d, r);
    chk(d === 32'h1C000000 && r === 2'h0, "cfg word");
    axr(4'h8, d, r);
    chk(d[3:0] === 4'hF, "lock image");
    axw(4'h8, 32'h0000000E, r);
    chk(r === 2'h0, "lock write resp");
    axr(4'h8, d, r);
    chk(d[3:0] === 4'hE, "lock and");
    axr(4'h1, d, r);
    chk(r === 2'h2, "unmapped resp");
    @(posedge aclk);
    chip_erase <= 1'b1;
    @(posedge aclk);
    chip_erase <= 1'b0;
    axr(4'h8, d, r);
    chk(d[3:0] === 4'hF, "chip erase");
    $display("regs done");
  endtask
  task t_app;
    sreq(13'h0100, 13'h0040, 1'b0);
    chk(store_deny === 1'b1 && flash_write_start === 1'b0, "app store");
    axr(4'h4, d, r);
    chk(d[3] === 1'b1, "deny flagged");
    $display("app done");
  endtask
  task t_rww(input bit via_pl);
    axw(4'h0, 32'h2, r);
    fetch_pc <= 13'h1E00;
    sreq(13'h1C10, 13'h0040, 1'b0);
    chk(store_grant === 1'b1 && flash_write_start === 1'b1, "rww grant");
    chk(concurrent_read_busy_flag === 1'b1 && cpu_halt === 1'b0, "rww run");
    wdone;
    axr(4'h4, d, r);
    chk(d[0] === 1'b1, "busy bit");
    if (via_pl) begin
      @(posedge aclk);
      page_load <= 1'b1;
      @(posedge aclk);
      page_load <= 1'b0;
    end else axw(4'h0, 32'h1, r);
    @(posedge aclk);
    #1;
    chk(concurrent_read_busy_flag === 1'b0, "busy clear");
    $display("rww done");
  endtask
  task t_halting_region;
    sreq(13'h1C10, 13'h1C40, 1'b1);
    chk(store_grant === 1'b1 && flash_erase_start === 1'b1, "boot page");
    repeat (2) @(posedge aclk);
    #1;
    chk(cpu_halt === 1'b1, "halt held");
    wdone;
    chk(cpu_halt === 1'b0, "halt end");
    $display("halting_region done");
  endtask
  task t_fuse;
    @(posedge aclk);
    boot_size_fuses <= 2'h3;
    repeat (3) @(posedge aclk);
    axr(4'hC, d, r);
    chk(d === 32'h1F800003, "cfg small boot");
    sreq(13'h1C10, 13'h1C40, 1'b0);
    chk(store_deny === 1'b1, "moved boundary");
    sreq(13'h1F90, 13'h1C40, 1'b0);
    chk(store_grant === 1'b1 && cpu_halt === 1'b1, "fixed halt region");
    wdone;
    @(posedge aclk);
    boot_size_fuses <= 2'h0;
    repeat (3) @(posedge aclk);
    $display("fuse done");
  endtask
  task t_locks;
    static logic [7:0] rows [7] = '{8'hFC, 8'hE6, 8'hC3, 8'hDB, 8'hB4, 8'h31, 8'h79};
    bit bt;
    foreach (rows[i]) begin
      bt = rows[i][7:6] != 2'b11;
      @(posedge aclk);
      chip_erase <= 1'b1;
      fetch_pc <= bt ? 13'h1E00 : 13'h0100;
      @(posedge aclk);
      chip_erase <= 1'b0;
      prog_lock_set <= 1'b1;
      prog_lock_data <= rows[i][7:4];
      @(posedge aclk);
      prog_lock_set <= 1'b0;
      axw(4'h0, {30'h0, rows[i][1], 1'b0}, r);
      axr(4'h8, d, r);
      chk(d[3:0] === rows[i][7:4], "lock set");
      sreq(13'h1C10, bt ? 13'h1F00 : 13'h0040, 1'b0);
      chk(store_grant === rows[i][3], "store lock");
      if (store_grant === 1'b1) wdone;
      lreq(bt ? 13'h0100 : 13'h1C10, bt ? 13'h1E00 : 13'h0040);
      chk(load_grant === rows[i][2], "load lock");
      chk(irq_suppress === rows[i][0], "irq gate");
    end
    $display("locks done");
  endtask
  initial begin
    repeat (5000) @(posedge aclk);
    err_total++;
    $display("BAD %0t watchdog", $time);
    close_out;
  end
  initial begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, prog_lock_set, chip_erase} = '0;
    {store_req, store_erase, load_req, page_load, aresetn, boot_size_fuses} = '0;
    {s_awaddr, s_araddr, s_wdata, prog_lock_data} = '0;
    {store_pc, store_page, load_pc, load_addr, fetch_pc} = '0;
    lock_stored = 4'hF;
    s_wstrb = 4'hF;
    err_total = 0;
    checks_done = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    t_regs;
    t_app;
    t_rww(1'b0);
    t_rww(1'b1);
    t_halting_region;
    t_fuse;
    t_locks;
    close_out;
  end
endmodule
